// ---- hdl/tlbe_top.sv ----
// data and fetch translation buffers with their register moves and lookup
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// [R1] kill write invalidates targeted entry, locally
// [R2] kill register write-only, zero at reset
// [R3] register moves only in supervisor mode
// [R4] each way has up to 128 entries
// [R5] address plus context compared against tags
// [R6] page number bits 31-13 must match
// [R7] bit0 valid, bit1 page level, reset zero
// [R8] context field 5-2 must match context
// [R9] context bits may be hardwired zero
// [R10] recency field 7-6, reset zero
// [R11] data hit supplies frame bits 31-13
// [R12] data bits 9-6 gate supervisor/user stores/loads
// [R13] bits 3-0 give cache and ordering attributes
// [R14] bit4 accessed, bit5 dirty
// [R15] fetch hit supplies frame, same attribute bits
// [R16] fetch bits 6,7 gate supervisor/user fetch
// [R17] other fields unreset; reserved bits read zero (fetch translate bits 12-8 are not masked and read back as written)
// [R18] kill clears valid in matching ways
// [R19] report fault on denied hit, miss otherwise
module tlbe_top #(
   parameter int   NWAYS   = 4,
   parameter int   SETS    = 128,
   parameter logic HAS_CID = 1'b1
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // special-purpose register moves
   input  wire logic        spr_wr,
   input  wire logic        spr_rd,
   input  wire logic [15:0] spr_addr,
   input  wire logic [31:0] spr_wdata,
   output var  logic [31:0] spr_rdata_ff,
   output var  logic        spr_rvalid_ff,
   // processor mode and context
   input  wire logic        sup_mode,
   input  wire logic [3:0]  status_context_id,
   // data lookup
   input  wire logic        dlk_req,
   input  wire logic [31:0] dlk_ea,
   input  wire logic        dlk_store,
   output var  logic        dlk_done_ff,
   output var  logic        dlk_miss_ff,
   output var  logic        dlk_fault_ff,
   output var  logic [31:0] dlk_phys_ff,
   output var  logic [3:0]  dlk_attr_ff,
   // fetch lookup
   input  wire logic        flk_req,
   input  wire logic [31:0] flk_ea,
   output var  logic        flk_done_ff,
   output var  logic        flk_miss_ff,
   output var  logic        flk_fault_ff,
   output var  logic [31:0] flk_phys_ff,
   output var  logic [3:0]  flk_attr_ff
);
   localparam int NU   = tlbe_pkg::NUM_UNITS;
   localparam int SETW = (SETS > 1) ? $clog2(SETS) : 1;

   // register address decode
   wire  logic [4:0]  spr_grp;
   wire  logic [10:0] spr_reg;
   wire  logic [10:0] way_off;
   wire  logic [1:0]  way_sel;
   wire  logic [6:0]  ent_sel;
   wire  logic        is_xl;
   wire  logic        in_ways;
   wire  logic        is_kill;
   wire  logic        slot_ok;
   wire  logic        wr_ok;
   wire  logic        rd_ok;
   wire  logic [SETW-1:0] sw_idx;
   wire  logic [NU-1:0]   unit_sel;

   assign spr_grp  = spr_addr[tlbe_pkg::GRP_LSB +: tlbe_pkg::GRP_W];
   assign spr_reg  = spr_addr[tlbe_pkg::REG_W-1:0];
   assign way_off  = spr_reg - tlbe_pkg::REG_WAY_BASE;
   assign way_sel  = way_off[tlbe_pkg::OFF_WAY_LSB +: 2];
   assign is_xl    = way_off[tlbe_pkg::OFF_XL_BIT];
   assign ent_sel  = way_off[tlbe_pkg::OFF_ENT_W-1:0];
   assign in_ways  = (spr_reg >= tlbe_pkg::REG_WAY_BASE) && (spr_reg < tlbe_pkg::REG_WAY_END);
   assign is_kill  = spr_reg == tlbe_pkg::REG_KILL;
   // entries past SETS and ways past NWAYS are unmapped
   assign slot_ok  = in_ways && (int'(ent_sel) < SETS) && (int'(way_sel) < NWAYS); // [R4]
   assign sw_idx   = ent_sel[SETW-1:0];
   assign unit_sel[tlbe_pkg::UNIT_DATA]  = spr_grp == tlbe_pkg::GRP_DATA;
   assign unit_sel[tlbe_pkg::UNIT_FETCH] = spr_grp == tlbe_pkg::GRP_FETCH;
   // user-mode moves are dropped: no store, reads return zero
   assign wr_ok    = spr_wr && sup_mode; // [R3]
   assign rd_ok    = spr_rd && sup_mode; // [R3]

   // lookup requests gathered per unit
   wire  logic [NU-1:0] lk_req;
   wire  logic [NU-1:0] lk_store;
   wire  logic [31:0]   lk_ea [NU];
   wire  logic [3:0]    cid_eff;

   assign lk_req[tlbe_pkg::UNIT_DATA]    = dlk_req;
   assign lk_req[tlbe_pkg::UNIT_FETCH]   = flk_req;
   assign lk_store[tlbe_pkg::UNIT_DATA]  = dlk_store;
   assign lk_store[tlbe_pkg::UNIT_FETCH] = 1'b0;
   assign lk_ea[tlbe_pkg::UNIT_DATA]     = dlk_ea;
   assign lk_ea[tlbe_pkg::UNIT_FETCH]    = flk_ea;
   // without fast context switching every entry matches context zero
   assign cid_eff  = HAS_CID ? status_context_id : 4'h0; // [R9]

   // kill register per unit; the invalidate lands one cycle after the write
   logic [31:0]   kill_ea_ff [NU];
   logic [NU-1:0] kill_pend_ff;
   logic [NU-1:0] nxt_kill_pend;

   assign nxt_kill_pend = (wr_ok && is_kill) ? unit_sel : '0; // [R1]

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         kill_pend_ff <= '0;
         for (int u = 0; u < NU; u++)
         begin
            kill_ea_ff[u] <= tlbe_pkg::KILL_RST; // [R2]
         end
      end
      else
      begin
         kill_pend_ff <= nxt_kill_pend;
         for (int u = 0; u < NU; u++)
         begin
            if (nxt_kill_pend[u])
            begin
               kill_ea_ff[u] <= spr_wdata; // [R2]
            end
         end
      end
   end

   // per-way results
   logic [NWAYS-1:0] hit_w  [NU];
   logic [31:0]      xl_w   [NU][NWAYS];
   logic [31:0]      rtag_w [NU][NWAYS];
   logic [31:0]      rxl_w  [NU][NWAYS];
   logic [NU-1:0]    hit_any;
   logic [NU-1:0]    perm_ok;
   logic [31:0]      hit_xl [NU];

   for (genvar u = 0; u < NU; u++)
   begin : g_unit
      wire logic [SETW-1:0] lk_idx;
      wire logic [SETW-1:0] kl_idx;
      wire logic            upd_ok;

      assign lk_idx = lk_ea[u][tlbe_pkg::VPN_LSB +: SETW];
      assign kl_idx = kill_ea_ff[u][tlbe_pkg::VPN_LSB +: SETW]; // [R18]
      assign upd_ok = lk_req[u] && perm_ok[u];

      for (genvar w = 0; w < NWAYS; w++)
      begin : g_way
         tlbe_way #(
            .SETS    (SETS),
            .SETW    (SETW),
            .TAG_MSK (HAS_CID ? tlbe_pkg::TAG_MASK : tlbe_pkg::TAG_MASK_NOCID),
            .XL_MSK  ((u == tlbe_pkg::UNIT_DATA) ? tlbe_pkg::DXL_MASK : tlbe_pkg::FXL_MASK)
         ) u_way (
            .mclk      (mclk),
            .rst       (rst),
            .lk_idx    (lk_idx),
            .lk_vpn    (lk_ea[u][31:tlbe_pkg::VPN_LSB]),
            .lk_cid    (cid_eff),
            .lk_hit    (hit_w[u][w]),
            .lk_xlate  (xl_w[u][w]),
            .acc_set   (upd_ok && hit_w[u][w]),
            .dirty_set (upd_ok && hit_w[u][w] && lk_store[u]),
            .sw_idx    (sw_idx),
            .tag_we    (wr_ok && unit_sel[u] && slot_ok && !is_xl && (int'(way_sel) == w)),
            .xl_we     (wr_ok && unit_sel[u] && slot_ok && is_xl && (int'(way_sel) == w)),
            .sw_wdata  (spr_wdata),
            .rd_tag    (rtag_w[u][w]),
            .rd_xlate  (rxl_w[u][w]),
            .kill_en   (kill_pend_ff[u]),
            .kill_idx  (kl_idx),
            .kill_vpn  (kill_ea_ff[u][31:tlbe_pkg::VPN_LSB])
         );
      end

      // lowest way wins if software loaded duplicate tags
      always_comb
      begin
         hit_any[u] = 1'b0;
         hit_xl[u]  = tlbe_pkg::WORD_ZERO;
         for (int w = NWAYS - 1; w >= 0; w--)
         begin
            if (hit_w[u][w])
            begin
               hit_any[u] = 1'b1;
               hit_xl[u]  = xl_w[u][w];
            end
         end
      end

      if (u == tlbe_pkg::UNIT_DATA)
      begin : g_dperm
         wire logic sup_bit;
         wire logic usr_bit;
         assign sup_bit = lk_store[u] ? hit_xl[u][tlbe_pkg::D_SUP_STORE]
                                      : hit_xl[u][tlbe_pkg::D_SUP_LOAD]; // [R12]
         assign usr_bit = lk_store[u] ? hit_xl[u][tlbe_pkg::D_USER_STORE]
                                      : hit_xl[u][tlbe_pkg::D_USER_LOAD]; // [R12]
         assign perm_ok[u] = hit_any[u] && (sup_mode ? sup_bit : usr_bit);
      end
      else
      begin : g_fperm
         assign perm_ok[u] = hit_any[u] && (sup_mode ? hit_xl[u][tlbe_pkg::F_SUP_FETCH]
                                                     : hit_xl[u][tlbe_pkg::F_USER_FETCH]); // [R16]
      end
   end

   // lookup results, one cycle after the request
   logic [NU-1:0] done_ff;
   logic [NU-1:0] miss_ff;
   logic [NU-1:0] fault_ff;
   logic [31:0]   phys_ff [NU];
   logic [3:0]    attr_ff [NU];
   logic [31:0]   nxt_phys [NU];
   logic [3:0]    nxt_attr [NU];

   always_comb
   begin
      for (int u = 0; u < NU; u++)
      begin
         nxt_phys[u] = tlbe_pkg::WORD_ZERO;
         nxt_attr[u] = 4'h0;
         if (hit_any[u])
         begin
            // frame from the hit entry, page offset from the request
            nxt_phys[u] = {hit_xl[u][31:tlbe_pkg::PFN_LSB],
                           lk_ea[u][tlbe_pkg::PFN_LSB-1:0]}; // [R11] [R15]
            nxt_attr[u] = hit_xl[u][tlbe_pkg::XL_CC +: tlbe_pkg::ATTR_W]; // [R13] [R15]
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         done_ff  <= '0;
         miss_ff  <= '0;
         fault_ff <= '0;
         for (int u = 0; u < NU; u++)
         begin
            phys_ff[u] <= tlbe_pkg::WORD_ZERO;
            attr_ff[u] <= 4'h0;
         end
      end
      else
      begin
         done_ff  <= lk_req;
         miss_ff  <= lk_req & ~hit_any; // [R19]
         fault_ff <= lk_req & hit_any & ~perm_ok; // [R19]
         for (int u = 0; u < NU; u++)
         begin
            phys_ff[u] <= nxt_phys[u];
            attr_ff[u] <= nxt_attr[u];
         end
      end
   end

   assign dlk_done_ff  = done_ff[tlbe_pkg::UNIT_DATA];
   assign dlk_miss_ff  = miss_ff[tlbe_pkg::UNIT_DATA];
   assign dlk_fault_ff = fault_ff[tlbe_pkg::UNIT_DATA];
   assign dlk_phys_ff  = phys_ff[tlbe_pkg::UNIT_DATA];
   assign dlk_attr_ff  = attr_ff[tlbe_pkg::UNIT_DATA];
   assign flk_done_ff  = done_ff[tlbe_pkg::UNIT_FETCH];
   assign flk_miss_ff  = miss_ff[tlbe_pkg::UNIT_FETCH];
   assign flk_fault_ff = fault_ff[tlbe_pkg::UNIT_FETCH];
   assign flk_phys_ff  = phys_ff[tlbe_pkg::UNIT_FETCH];
   assign flk_attr_ff  = attr_ff[tlbe_pkg::UNIT_FETCH];

   // register read path; the kill register and unmapped slots read zero
   logic [31:0] nxt_rdata;

   always_comb
   begin
      nxt_rdata = tlbe_pkg::WORD_ZERO;
      for (int u = 0; u < NU; u++)
      begin
         for (int w = 0; w < NWAYS; w++)
         begin
            if (rd_ok && unit_sel[u] && slot_ok && (int'(way_sel) == w))
            begin
               nxt_rdata = is_xl ? rxl_w[u][w] : rtag_w[u][w]; // [R3] [R17]
            end
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         spr_rdata_ff  <= tlbe_pkg::WORD_ZERO;
         spr_rvalid_ff <= 1'b0;
      end
      else
      begin
         spr_rdata_ff  <= nxt_rdata; // [R2]
         spr_rvalid_ff <= spr_rd;
      end
   end
endmodule
`default_nettype wire

// ---- hdl/tlbe_pkg.sv ----
// shared constants for the translation buffer entry block
package tlbe_pkg;
   // special-purpose register address split: group in [15:11], register in [10:0]
   localparam int          SPR_AW        = 16;
   localparam int          GRP_LSB       = 11;
   localparam int          GRP_W         = 5;
   localparam int          REG_W         = 11;
   localparam logic [4:0]  GRP_DATA      = 5'h01;
   localparam logic [4:0]  GRP_FETCH     = 5'h02;
   localparam logic [10:0] REG_KILL      = 11'h002;
   localparam logic [10:0] REG_WAY_BASE  = 11'h200;
   localparam logic [10:0] REG_WAY_END   = 11'h600;
   // layout of the offset above the way base
   localparam int          OFF_WAY_LSB   = 8;
   localparam int          OFF_XL_BIT    = 7;
   localparam int          OFF_ENT_W     = 7;

   // match word fields
   localparam int          VPN_LSB       = 13;
   localparam int          VPN_W         = 19;
   localparam int          TAG_VALID     = 0;
   localparam int          TAG_PL1       = 1;
   localparam int          TAG_CID_LSB   = 2;
   localparam int          CID_W         = 4;
   localparam int          TAG_LRU_LSB   = 6;
   localparam int          LRU_W         = 2;
   localparam logic [31:0] TAG_MASK      = 32'hffffe0ff;
   localparam logic [31:0] TAG_MASK_NOCID = 32'hffffe0c3;
   localparam logic [31:0] TAG_RST_KEEP  = 32'hffffff3c;

   // translate word fields
   localparam int          PFN_LSB       = 13;
   localparam int          XL_CC         = 0;
   localparam int          XL_CI         = 1;
   localparam int          XL_WBC        = 2;
   localparam int          XL_WOM        = 3;
   localparam int          XL_ACC        = 4;
   localparam int          XL_DIRTY      = 5;
   localparam int          ATTR_W        = 4;
   localparam int          D_USER_LOAD   = 6;
   localparam int          D_USER_STORE  = 7;
   localparam int          D_SUP_LOAD    = 8;
   localparam int          D_SUP_STORE   = 9;
   localparam int          F_SUP_FETCH   = 6;
   localparam int          F_USER_FETCH  = 7;
   localparam logic [31:0] DXL_MASK      = 32'hffffe3ff;
   localparam logic [31:0] FXL_MASK      = 32'hffffffff;

   // units and reset values
   localparam int          UNIT_DATA     = 0;
   localparam int          UNIT_FETCH    = 1;
   localparam int          NUM_UNITS     = 2;
   localparam logic [31:0] KILL_RST      = 32'h00000000;
   localparam logic [31:0] WORD_ZERO     = 32'h00000000;
endpackage

// ---- hdl/tlbe_way.sv ----
// one way of a translation buffer: match and translate words for every set
`timescale 1ns/1ns
`default_nettype none
module tlbe_way #(
   parameter int          SETS    = 128,
   parameter int          SETW    = 7,
   parameter logic [31:0] TAG_MSK = 32'hffffe0ff,
   parameter logic [31:0] XL_MSK  = 32'hffffffff
) (
   // clock and reset
   input  wire logic                      mclk,
   input  wire logic                      rst,
   // lookup
   input  wire logic [SETW-1:0]           lk_idx,
   input  wire logic [tlbe_pkg::VPN_W-1:0] lk_vpn,
   input  wire logic [tlbe_pkg::CID_W-1:0] lk_cid,
   output logic                           lk_hit,
   output logic [31:0]                    lk_xlate,
   input  wire logic                      acc_set,
   input  wire logic                      dirty_set,
   // software access
   input  wire logic [SETW-1:0]           sw_idx,
   input  wire logic                      tag_we,
   input  wire logic                      xl_we,
   input  wire logic [31:0]               sw_wdata,
   output logic [31:0]                    rd_tag,
   output logic [31:0]                    rd_xlate,
   // entry kill
   input  wire logic                      kill_en,
   input  wire logic [SETW-1:0]           kill_idx,
   input  wire logic [tlbe_pkg::VPN_W-1:0] kill_vpn
);
   logic [31:0] tag_ff [SETS];
   logic [31:0] xl_ff  [SETS];
   wire  logic [31:0] lk_tag;
   wire  logic [31:0] kill_tag;
   wire  logic        kill_hit;

   assign lk_tag   = tag_ff[lk_idx];
   assign lk_xlate = xl_ff[lk_idx];
   // valid entry whose page number and context both match
   assign lk_hit   = lk_tag[tlbe_pkg::TAG_VALID]
                   && (lk_tag[31:tlbe_pkg::VPN_LSB] == lk_vpn)
                   && (lk_tag[tlbe_pkg::TAG_CID_LSB +: tlbe_pkg::CID_W] == lk_cid); // [R5] [R6] [R8]
   // reserved match and data translate bits read zero even before software first loads the word
   assign rd_tag   = tag_ff[sw_idx] & TAG_MSK; // [R17]
   assign rd_xlate = xl_ff[sw_idx] & XL_MSK; // [R17]
   assign kill_tag = tag_ff[kill_idx];
   // kill ignores context so a stale entry of any context goes
   assign kill_hit = kill_tag[31:tlbe_pkg::VPN_LSB] == kill_vpn; // [R18]

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         // only valid, page level and recency are cleared; the rest is left alone
         for (int i = 0; i < SETS; i++)
         begin
            tag_ff[i] <= tag_ff[i] & tlbe_pkg::TAG_RST_KEEP; // [R7] [R10] [R17]
         end
      end
      else
      begin
         if (kill_en && kill_hit)
         begin
            tag_ff[kill_idx][tlbe_pkg::TAG_VALID] <= 1'b0; // [R1] [R18]
         end
         // a software load after the kill in the same cycle wins
         if (tag_we)
         begin
            tag_ff[sw_idx] <= sw_wdata & TAG_MSK; // [R9] [R17]
         end
         if (xl_we)
         begin
            xl_ff[sw_idx] <= sw_wdata & XL_MSK; // [R17]
         end
         // hardware set of accessed and dirty wins over a software write
         if (acc_set)
         begin
            xl_ff[lk_idx][tlbe_pkg::XL_ACC] <= 1'b1; // [R14]
         end
         if (dirty_set)
         begin
            xl_ff[lk_idx][tlbe_pkg::XL_DIRTY] <= 1'b1; // [R14]
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/tlbe_props.sv ----
// concurrent checks on the ports of the translation buffer entry block
`timescale 1ns/1ns
`default_nettype none
module tlbe_props #(
   parameter int   NWAYS   = 4,
   parameter int   SETS    = 128,
   parameter logic HAS_CID = 1'b1
) (
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   // register moves
   input wire logic        spr_wr,
   input wire logic        spr_rd,
   input wire logic [15:0] spr_addr,
   input wire logic [31:0] spr_wdata,
   input wire logic [31:0] spr_rdata_ff,
   input wire logic        spr_rvalid_ff,
   input wire logic        sup_mode,
   input wire logic [3:0]  status_context_id,
   // data lookup
   input wire logic        dlk_req,
   input wire logic [31:0] dlk_ea,
   input wire logic        dlk_store,
   input wire logic        dlk_done_ff,
   input wire logic        dlk_miss_ff,
   input wire logic        dlk_fault_ff,
   input wire logic [31:0] dlk_phys_ff,
   input wire logic [3:0]  dlk_attr_ff,
   // fetch lookup
   input wire logic        flk_req,
   input wire logic [31:0] flk_ea,
   input wire logic        flk_done_ff,
   input wire logic        flk_miss_ff,
   input wire logic        flk_fault_ff,
   input wire logic [31:0] flk_phys_ff,
   input wire logic [3:0]  flk_attr_ff
);
   logic grp_ok;
   logic way_ok;
   assign grp_ok = spr_addr[15:11] == 5'h01 || spr_addr[15:11] == 5'h02;
   assign way_ok = spr_addr[10:0] >= 11'h200 && spr_addr[10:0] < 11'h200 + 256 * NWAYS;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_read_answer: assert property (spr_rd |=> spr_rvalid_ff)
      else $error("read not answered after one cycle");
   a_answer_cause: assert property (spr_rvalid_ff |-> $past(spr_rd))
      else $error("read answer without a read");
   a_user_read: assert property (spr_rd && !sup_mode |=> spr_rdata_ff == 32'h0)
      else $error("user mode read returned data");
   a_kill_hidden: assert property (spr_rd && spr_addr[10:0] == 11'h002 |=> spr_rdata_ff == 32'h0)
      else $error("kill register readable");
   a_data_answer: assert property (dlk_req |=> dlk_done_ff)
      else $error("data lookup not answered");
   a_fetch_answer: assert property (flk_req |=> flk_done_ff ##1 (!flk_done_ff || $past(flk_req)))
      else $error("fetch lookup answer wrong length");
   a_miss_quiet: assert property (dlk_miss_ff |-> dlk_done_ff && !dlk_fault_ff
      && dlk_phys_ff == 32'h0 && dlk_attr_ff == 4'h0)
      else $error("data miss with payload");
   a_data_offset: assert property (dlk_done_ff && !dlk_miss_ff |-> dlk_phys_ff[12:0] == $past(dlk_ea[12:0]))
      else $error("data page offset not passed");
   a_fetch_offset: assert property (flk_done_ff && !flk_miss_ff |-> flk_phys_ff[12:0] == $past(flk_ea[12:0]))
      else $error("fetch page offset not passed");
   a_xl_reserved: assert property (spr_rd && sup_mode && spr_addr[15:11] == 5'h01 && way_ok
      && spr_addr[7] |=> spr_rdata_ff[12:10] == 3'h0)
      else $error("data translate reserved bits read set");
   a_tag_reserved: assert property (spr_rd && sup_mode && grp_ok && way_ok && !spr_addr[7]
      |=> spr_rdata_ff[12:8] == 5'h00)
      else $error("match reserved bits read set");
   c_data_fault: cover property (dlk_done_ff && dlk_fault_ff);
   c_fetch_hit: cover property (flk_done_ff && !flk_miss_ff && !flk_fault_ff);
   c_kill_write: cover property (spr_wr && sup_mode && spr_addr[10:0] == 11'h002);
endmodule
bind tlbe_top tlbe_props #(.NWAYS(NWAYS), .SETS(SETS), .HAS_CID(HAS_CID)) i_tlbe_props (
   .mclk(mclk), .rst(rst), .spr_wr(spr_wr), .spr_rd(spr_rd), .spr_addr(spr_addr),
   .spr_wdata(spr_wdata), .spr_rdata_ff(spr_rdata_ff), .spr_rvalid_ff(spr_rvalid_ff),
   .sup_mode(sup_mode), .status_context_id(status_context_id), .dlk_req(dlk_req),
   .dlk_ea(dlk_ea), .dlk_store(dlk_store), .dlk_done_ff(dlk_done_ff),
   .dlk_miss_ff(dlk_miss_ff), .dlk_fault_ff(dlk_fault_ff), .dlk_phys_ff(dlk_phys_ff),
   .dlk_attr_ff(dlk_attr_ff), .flk_req(flk_req), .flk_ea(flk_ea),
   .flk_done_ff(flk_done_ff), .flk_miss_ff(flk_miss_ff), .flk_fault_ff(flk_fault_ff),
   .flk_phys_ff(flk_phys_ff), .flk_attr_ff(flk_attr_ff));
`default_nettype wire

// ---- tb/tlbe_pipe_model.sv ----
// pipeline model that presents fetch and load/store addresses
`timescale 1ns/1ns
`default_nettype none
module tlbe_pipe_model (
   // clock
   input  wire logic        mclk,
   // lookup requests
   output logic             dlk_req,
   output logic [31:0]      dlk_ea,
   output logic             dlk_store,
   output logic             flk_req,
   output logic [31:0]      flk_ea
);
   initial
   begin
      dlk_req = 1'b0;
      flk_req = 1'b0;
      dlk_ea = 32'h0;
      flk_ea = 32'h0;
      dlk_store = 1'b0;
   end
   // one request per call; the address is scrambled after, as a real pipeline moves on
   task automatic issue(input int u, input logic [31:0] ea, input bit st);
      @(negedge mclk);
      if (u == 0)
      begin
         dlk_req = 1'b1;
         dlk_ea = ea;
         dlk_store = st;
      end
      else
      begin
         flk_req = 1'b1;
         flk_ea = ea;
      end
      @(negedge mclk);
      dlk_req = 1'b0;
      flk_req = 1'b0;
      dlk_ea = ~ea;
      flk_ea = ~ea;
      dlk_store = ~st;
   endtask
endmodule
`default_nettype wire

// ---- tb/tlbe_top_tb.sv ----
// self-checking bench for the translation buffer entry block
`timescale 1ns/1ns
`default_nettype none
module tlbe_top_tb;
   localparam int NW = 4;
   logic        mclk, rst, spr_wr, spr_rd, sup_mode, spr_rvalid_ff;
   logic [15:0] spr_addr;
   logic [31:0] spr_wdata, spr_rdata_ff, dlk_ea, flk_ea, dlk_phys_ff, flk_phys_ff;
   logic [3:0]  status_context_id, dlk_attr_ff, flk_attr_ff;
   logic        dlk_req, dlk_store, flk_req, dlk_done_ff, dlk_miss_ff, dlk_fault_ff;
   logic        flk_done_ff, flk_miss_ff, flk_fault_ff;
   logic [31:0] regs[int];
   logic [31:0] lf, q, d, ea, v;
   int          n_errors, n_checks, cycles, k;
   tlbe_top #(.NWAYS(NW)) i_tlbe_top (.mclk(mclk), .rst(rst), .spr_wr(spr_wr),
      .spr_rd(spr_rd), .spr_addr(spr_addr), .spr_wdata(spr_wdata),
      .spr_rdata_ff(spr_rdata_ff), .spr_rvalid_ff(spr_rvalid_ff), .sup_mode(sup_mode),
      .status_context_id(status_context_id), .dlk_req(dlk_req), .dlk_ea(dlk_ea),
      .dlk_store(dlk_store), .dlk_done_ff(dlk_done_ff), .dlk_miss_ff(dlk_miss_ff),
      .dlk_fault_ff(dlk_fault_ff), .dlk_phys_ff(dlk_phys_ff), .dlk_attr_ff(dlk_attr_ff),
      .flk_req(flk_req), .flk_ea(flk_ea), .flk_done_ff(flk_done_ff),
      .flk_miss_ff(flk_miss_ff), .flk_fault_ff(flk_fault_ff), .flk_phys_ff(flk_phys_ff),
      .flk_attr_ff(flk_attr_ff));
   tlbe_pipe_model i_tlbe_pipe_model (.mclk(mclk), .dlk_req(dlk_req), .dlk_ea(dlk_ea),
      .dlk_store(dlk_store), .flk_req(flk_req), .flk_ea(flk_ea));
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   function automatic logic [31:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         n_errors++;
         close_out();
      end
   end
   // one register move; the model follows only what supervisor mode may do
   task automatic spr(input bit wr, input logic [15:0] a, input logic [31:0] wd);
      logic [4:0] g;
      g = a[15:11];
      @(negedge mclk);
      spr_wr = wr;
      spr_rd = !wr;
      spr_addr = a;
      spr_wdata = wd;
      @(negedge mclk);
      spr_wr = 1'b0;
      spr_rd = 1'b0;
      spr_wdata = ~wd;
      q = spr_rdata_ff;
      if (!wr)
         chk({31'h0, spr_rvalid_ff}, 32'h1, "read valid");
      if (wr && sup_mode && (g == 5'h01 || g == 5'h02))
      begin
         if (a[10:0] >= 11'h200 && a[10:0] < 11'h200 + 256 * NW)
            regs[a] = wd & (a[7] ? (g == 5'h01 ? tlbe_pkg::DXL_MASK : tlbe_pkg::FXL_MASK)
               : tlbe_pkg::TAG_MASK);
         else if (a[10:0] == tlbe_pkg::REG_KILL)
            for (int y = 0; y < NW; y++)
            begin
               k = g * 2048 + 512 + 256 * y + wd[19:13];
               if (regs.exists(k) && regs[k][31:13] == wd[31:13])
                  regs[k][0] = 1'b0;
            end
      end
   endtask
   task automatic rdchk(input logic [15:0] a);
      spr(1'b0, a, 32'h0);
      chk(q, regs[a], "read back");
   endtask
   // lowest matching way wins; accessed and dirty only on a permitted hit
   task automatic look(input int u, input logic [31:0] la, input bit st);
      int h;
      logic [31:0] x;
      logic [31:0] got;
      bit ok;
      h = -1;
      for (int y = NW - 1; y >= 0; y--)
      begin
         k = (u + 1) * 2048 + 512 + 256 * y + la[19:13];
         if (regs.exists(k) && regs[k][0] && regs[k][31:13] == la[31:13]
             && regs[k][5:2] == status_context_id)
            h = k;
      end
      x = (h >= 0) ? regs[h + 128] : 32'h0;
      ok = (u == 0) ? (sup_mode ? x[8 + st] : x[6 + st]) : (sup_mode ? x[6] : x[7]);
      i_tlbe_pipe_model.issue(u, la, st);
      got = (u == 0) ? {dlk_done_ff, dlk_miss_ff, dlk_fault_ff, dlk_attr_ff, dlk_phys_ff[31:13]}
         : {flk_done_ff, flk_miss_ff, flk_fault_ff, flk_attr_ff, flk_phys_ff[31:13]};
      chk(got, (h < 0) ? 32'h3000000 : {6'h0, 1'b1, 1'b0, !ok, x[3:0], x[31:13]},
         "lookup result");
      if (h >= 0 && ok)
         regs[h + 128] = x | 32'h10 | ((u == 0 && st) ? 32'h20 : 32'h0);
   endtask
   initial
   begin
      lf = 32'd34456;
      rst = 1'b1;
      {spr_wr, spr_rd, spr_addr, spr_wdata} = '0;
      sup_mode = 1'b1;
      status_context_id = 4'h3;
      {cycles, n_errors, n_checks} = '0;
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      spr(1'b0, 16'h0b05, 32'h0);
      chk(q & 32'hc3, 32'h0, "match reset");
      spr(1'b0, 16'h1002, 32'h0);
      chk(q, 32'h0, "kill read");
      $display("reset test done");
      for (int i = 0; i < 24; i++)
      begin
         d = (i % 2 + 1) * 2048 + 512 + 256 * (rnd() % NW) + (i == 0 ? 127 : rnd() % 128)
            + (rnd() % 2) * 128;
         spr(1'b1, d[15:0], rnd() & 32'hfffffffe);
         rdchk(d[15:0]);
      end
      sup_mode = 1'b0;
      spr(1'b1, d[15:0], 32'h5555aaaa);
      spr(1'b0, d[15:0], 32'h0);
      chk(q, 32'h0, "user read");
      sup_mode = 1'b1;
      rdchk(d[15:0]);
      spr(1'b0, 16'h1a00, 32'h0);
      chk(q, 32'h0, "unmapped read");
      $display("register test done");
      for (int i = 0; i < 40; i++)
      begin
         v = (rnd() & 32'hfff01fff) | (32'(16 + i) << 13);
         k = (i % 2 + 1) * 2048 + 512 + 256 * (i % NW) + 16 + i;
         spr(1'b1, k[15:0], {v[31:13], 5'h0, 2'h2, status_context_id, v[0], 1'b1});
         spr(1'b1, k[15:0] + 16'd128, rnd());
         ea = v;
         if (i % 5 == 0)
            ea[31] = ~ea[31];
         if (i % 7 == 3)
            status_context_id = 4'h4;
         sup_mode = 1'(rnd() % 2);
         look(i % 2, ea, (i % 2 == 0) && v[1]);
         sup_mode = 1'b1;
         status_context_id = 4'h3;
         rdchk(k[15:0] + 16'd128);
      end
      $display("lookup test done");
      v = (rnd() & 32'hfff00000) | 32'h00050000;
      for (int u = 0; u < 2; u++)
         for (int y = 1; y < 3; y++)
         begin
            k = (u + 1) * 2048 + 512 + 256 * y + 40;
            spr(1'b1, k[15:0], {v[31:13] ^ 19'(y - 1), 7'h0, status_context_id, 2'h1});
            spr(1'b1, k[15:0] + 16'd128, 32'hffffffff);
         end
      ea = {v[31:13], 13'h123};
      for (int u = 0; u < 2; u++)
      begin
         spr(1'b1, 16'((u + 1) * 2048 + 2), ea);
         repeat (2) @(negedge mclk);
         look(0, ea, 1'b0);
         look(1, ea, 1'b0);
         rdchk(16'((u + 1) * 2048 + 808));
      end
      $display("kill test done");
      close_out();
   end
endmodule
`default_nettype wire
